//--- inc/mds_defines.svh
/*
 Constants of the motor driver I/O function layer: terminal function codes,
 factory terminal assignment and timing counts.
 Assumes a 100 MHz core clock; included by bare name wherever it is needed.
*/
`ifndef MDS_DEFINES_SVH
`define MDS_DEFINES_SVH

`define MDS_CLK_MHZ        100
`define MDS_HOLD_MIN_MS    10
`define MDS_FILT_US        1000
`define MDS_FILT_CYC       ((`MDS_FILT_US) * (`MDS_CLK_MHZ))
`define MDS_TACHO_W_US     200
`define MDS_TACHO_CYC      ((`MDS_TACHO_W_US) * (`MDS_CLK_MHZ))
`define MDS_TACHO_PER_REV  30

`define MDS_N_DIN          6
`define MDS_N_DOUT         4
`define MDS_N_IFUNC        16
`define MDS_N_NOTICE       18

// Input function codes
`define MDS_IF_START       4'h0
`define MDS_IF_HARD_STOP   4'h1
`define MDS_IF_DIR_SEL     4'h2
`define MDS_IF_SPD0        4'h3
`define MDS_IF_SPD1        4'h4
`define MDS_IF_FAULT_CLR   4'h5
`define MDS_IF_FWD         4'h6
`define MDS_IF_BWD         4'h7
`define MDS_IF_HALT_SEL    4'h8
`define MDS_IF_SPD2        4'h9
`define MDS_IF_TQ_EN       4'ha
`define MDS_IF_NOTICE_CLR  4'hb
`define MDS_IF_TOOL_UNLOCK 4'hc
`define MDS_IF_EXT_FAULT   4'hd
`define MDS_IF_SHAFT_REL   4'he
`define MDS_IF_NONE        4'hf

// Output function codes; NOTICE_BASE + i selects notice bit i
`define MDS_OF_TACHO       5'h00
`define MDS_OF_FAULT_NC    5'h01
`define MDS_OF_TQ_CAPPED   5'h02
`define MDS_OF_ROT_SENSE   5'h03
`define MDS_OF_FAULT_NO    5'h04
`define MDS_OF_MOVING      5'h05
`define MDS_OF_NOTICE_SUM  5'h06
`define MDS_OF_SPD_REACHED 5'h07
`define MDS_OF_NOTICE_BASE 5'h08

`define MDS_FACTORY_IN_MAP  {`MDS_IF_FAULT_CLR, `MDS_IF_SPD1, `MDS_IF_SPD0, `MDS_IF_DIR_SEL, `MDS_IF_HARD_STOP, `MDS_IF_START}
`define MDS_FACTORY_OUT_MAP {`MDS_OF_ROT_SENSE, `MDS_OF_TQ_CAPPED, `MDS_OF_FAULT_NC, `MDS_OF_TACHO}

`endif

//--- inc/mds_pkg.sv
/*
 Types of the motor driver I/O function layer: configuration, motor core
 status and command bundles.
 Assumes mds_defines.svh for the terminal and notice counts.
*/
`include "mds_defines.svh"

package mds_pkg;

   typedef enum logic [1:0] {
      MDS_STOP_DECEL,
      MDS_STOP_INSTANT,
      MDS_STOP_COAST
   } mds_stop_t;

   typedef struct packed {
      logic                                two_wire;
      logic                                notice_auto_clr;
      logic                                load_hold_en;
      logic                                map_custom;
      logic [`MDS_N_DIN-1:0][3:0]          in_map;
      logic [`MDS_N_DOUT-1:0][4:0]         out_map;
      logic [15:0]                         va_width;
   } mds_cfg_t;

   typedef struct packed {
      logic                                rotating;
      logic                                rot_fwd;
      logic                                torque_limited;
      logic                                shaft_step;
      logic                                shaft_held;
      logic                                alarm_event;
      logic                                alarm_locked;
      logic [15:0]                         speed_act;
      logic [15:0]                         speed_set;
      logic [`MDS_N_NOTICE-1:0]            notice_cond;
   } mds_core_t;

   typedef struct packed {
      logic                                run;
      logic                                dir_fwd;
      mds_stop_t                           stop_kind;
      logic [2:0]                          speed_no;
      logic                                torque_lim_en;
      logic                                tool_unlocked;
      logic                                shaft_free;
   } mds_cmd_t;

endpackage

//--- src/mds_top.sv
/*
 Digital I/O function layer of a brushless motor driver: filters six direct
 inputs, maps them onto run, stop, direction, speed number, alarm and notice
 functions, and drives four direct outputs from the driver status.
 Assumes all inputs synchronous to clk except the raw terminals, which are
 synchronised here; the motor core acts on cmd_ff and reports in core.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mds_defines.svh"

// Functional notes
// - Three-wire: run request on starts rotation, off gives decelerating stop.
// - Three-wire: hard-stop input on permits rotation, off forces instantaneous stop.
// - Three-wire: rotation direction follows the direction-select level.
// - Speed-select levels pick the operation data number; two default, third optional.
// - Fault-clear on edge resets the active alarm.
// - Two-wire: forward-run turns forward, backward-run turns backward.
// - Two-wire: halt-style-select picks decelerating or instantaneous stop on release.
// - Three-wire or two-wire input set chosen by configuration, not a pin.
// - Torque-cap-enable switches output torque limiting on or off.
// - Notice-clear on edge resets the present notice status.
// - Tool-unlock lifts configuration tool restrictions.
// - External fault forces the motor to stop over run commands.
// - Shaft-release frees an electrically held stopped shaft under load holding.
// - Tachometer output gives 30 pulses per output shaft revolution.
// - On alarm normally-closed fault output goes off, normally-open goes on.
// - Torque-capped output is on while torque is being limited.
// - Rotation-sense on in forward rotation, held until reverse rotation.
// - Moving output on while rotating, off otherwise.
// - Speed-reached on when detected speed within plus-minus window of set speed.
// - Each notice output turns on when its notice condition occurs.
// - Summary notice output reflects overall notice status.
// - Factory default terminal assignment fixed; other assignments set by configuration.
// - Speed-select bits form binary number 0 to 7, third most significant.
// - Each tachometer pulse is 0.2 ms wide.
// - Unassigned torque-cap, tool-unlock, external-fault read on; multi-assigned need all.
module mds_top #(
   parameter int FILT_CYC        = `MDS_FILT_CYC,
   parameter int TACHO_CYC       = `MDS_TACHO_CYC,
   parameter int STEPS_PER_PULSE = 1
) (
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic [`MDS_N_DIN-1:0]      direct_input,
   input  wire mds_pkg::mds_cfg_t          cfg,
   input  wire mds_pkg::mds_core_t         core,
   output logic [`MDS_N_DOUT-1:0]          direct_output_ff,
   output mds_pkg::mds_cmd_t               cmd_ff,
   output logic                            alarm_ff,
   output logic [`MDS_N_NOTICE-1:0]        notice_ff
);

   localparam int FW = $clog2(FILT_CYC + 1);
   localparam int TW = $clog2(TACHO_CYC + 1);
   localparam int SW = $clog2(STEPS_PER_PULSE + 1);

   // Two-wire mode reuses the three factory run terminals
   function automatic logic [3:0] eff_code(input logic [3:0] code, input logic two_wire);
      logic [3:0] r;
      r = code;
      if (two_wire) begin
         if (code == `MDS_IF_START) begin
            r = `MDS_IF_FWD;
         end else if (code == `MDS_IF_HARD_STOP) begin
            r = `MDS_IF_BWD;
         end else if (code == `MDS_IF_DIR_SEL) begin
            r = `MDS_IF_HALT_SEL;
         end
      end else if (code == `MDS_IF_FWD || code == `MDS_IF_BWD || code == `MDS_IF_HALT_SEL) begin
         r = `MDS_IF_NONE;
      end
      return r;
   endfunction

   logic [`MDS_N_DIN-1:0]      sync1_ff;
   logic [`MDS_N_DIN-1:0]      sync2_ff;
   logic [`MDS_N_DIN-1:0]      filt_ff;
   logic [`MDS_N_DIN-1:0][3:0] map;
   logic [`MDS_N_IFUNC-1:0]    fn;
   logic                       fault_clr_prev_ff;
   logic                       notice_clr_prev_ff;
   logic                       alarm_lock_ff;
   logic                       ext_stop_ff;
   logic                       rot_sense_ff;
   logic                       tacho_ff;
   logic [TW-1:0]              tacho_cnt_ff;
   logic [SW-1:0]              step_cnt_ff;
   logic                       run_inputs;
   logic                       fault_clr_edge;
   logic                       notice_clr_edge;
   logic                       ext_ok;
   logic                       speed_ok;
   logic [16:0]                speed_diff;
   mds_pkg::mds_cmd_t          nxt_cmd;

   assign map = cfg.map_custom ? cfg.in_map : `MDS_FACTORY_IN_MAP;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= direct_input;
         sync2_ff <= sync1_ff;
      end
   end

   // Filter settles well inside the controller's minimum hold time
   genvar gi;
   generate
      for (gi = 0; gi < `MDS_N_DIN; gi++) begin : g_filt
         logic [FW-1:0] cnt_ff;
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               cnt_ff        <= '0;
               filt_ff[gi]   <= 1'b0;
            end else if (sync2_ff[gi] == filt_ff[gi]) begin
               cnt_ff        <= '0;
            end else if (cnt_ff == FW'(FILT_CYC - 1)) begin
               cnt_ff        <= '0;
               filt_ff[gi]   <= sync2_ff[gi];
            end else begin
               cnt_ff        <= cnt_ff + FW'(1);
            end
         end
      end
   endgenerate

   always_comb begin
      logic [`MDS_N_IFUNC-1:0] assigned;
      logic [`MDS_N_IFUNC-1:0] all_on;
      logic [3:0]              c;
      assigned = '0;
      all_on   = '1;
      c        = 4'h0;
      for (int t = 0; t < `MDS_N_DIN; t++) begin
         c = eff_code(map[t], cfg.two_wire);
         assigned[c] = 1'b1;
         all_on[c]   = all_on[c] & filt_ff[t];
      end
      for (int f = 0; f < `MDS_N_IFUNC; f++) begin
         fn[f] = assigned[f] & all_on[f];
      end
      // Safety functions default to on when no terminal carries them
      if (!assigned[`MDS_IF_TQ_EN]) begin
         fn[`MDS_IF_TQ_EN] = 1'b1;
      end
      if (!assigned[`MDS_IF_TOOL_UNLOCK]) begin
         fn[`MDS_IF_TOOL_UNLOCK] = 1'b1;
      end
      if (!assigned[`MDS_IF_EXT_FAULT]) begin
         fn[`MDS_IF_EXT_FAULT] = 1'b1;
      end
      fn[`MDS_IF_NONE] = 1'b0;
   end

   assign ext_ok     = fn[`MDS_IF_EXT_FAULT];
   assign run_inputs = cfg.two_wire ? (fn[`MDS_IF_FWD] | fn[`MDS_IF_BWD])
                                    : (fn[`MDS_IF_START] & fn[`MDS_IF_HARD_STOP]);
   assign fault_clr_edge  = fn[`MDS_IF_FAULT_CLR] & ~fault_clr_prev_ff;
   assign notice_clr_edge = fn[`MDS_IF_NOTICE_CLR] & ~notice_clr_prev_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fault_clr_prev_ff  <= 1'b0;
         notice_clr_prev_ff <= 1'b0;
      end else begin
         fault_clr_prev_ff  <= fn[`MDS_IF_FAULT_CLR];
         notice_clr_prev_ff <= fn[`MDS_IF_NOTICE_CLR];
      end
   end

   // Alarm: a new cause in the clear cycle wins; clear is ignored while the run inputs are on
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         alarm_ff      <= 1'b0;
         alarm_lock_ff <= 1'b0;
         ext_stop_ff   <= 1'b0;
      end else if (core.alarm_event || !ext_ok) begin
         alarm_ff      <= 1'b1;
         alarm_lock_ff <= alarm_lock_ff | (core.alarm_event & core.alarm_locked);
         ext_stop_ff   <= ext_stop_ff | ~ext_ok;
      end else if (fault_clr_edge && !run_inputs && !alarm_lock_ff) begin
         alarm_ff      <= 1'b0;
         ext_stop_ff   <= 1'b0;
      end
   end

   // Notices: auto mode follows the cause, else sticky until clear edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         notice_ff <= '0;
      end else if (cfg.notice_auto_clr) begin
         notice_ff <= core.notice_cond;
      end else begin
         notice_ff <= core.notice_cond | (notice_ff & {`MDS_N_NOTICE{~notice_clr_edge}});
      end
   end

   always_comb begin
      nxt_cmd               = cmd_ff;
      nxt_cmd.speed_no      = {fn[`MDS_IF_SPD2], fn[`MDS_IF_SPD1], fn[`MDS_IF_SPD0]};
      nxt_cmd.torque_lim_en = fn[`MDS_IF_TQ_EN];
      nxt_cmd.tool_unlocked = fn[`MDS_IF_TOOL_UNLOCK];
      nxt_cmd.shaft_free    = cfg.load_hold_en & core.shaft_held & fn[`MDS_IF_SHAFT_REL];
      if (cfg.two_wire) begin
         if (fn[`MDS_IF_FWD] && !fn[`MDS_IF_BWD]) begin
            nxt_cmd.run       = 1'b1;
            nxt_cmd.dir_fwd   = 1'b1;
         end else if (fn[`MDS_IF_BWD] && !fn[`MDS_IF_FWD]) begin
            nxt_cmd.run       = 1'b1;
            nxt_cmd.dir_fwd   = 1'b0;
         end else if (fn[`MDS_IF_BWD] && fn[`MDS_IF_FWD]) begin
            nxt_cmd.run       = 1'b0;
            nxt_cmd.stop_kind = mds_pkg::MDS_STOP_DECEL;
         end else begin
            nxt_cmd.run       = 1'b0;
            nxt_cmd.stop_kind = fn[`MDS_IF_HALT_SEL] ? mds_pkg::MDS_STOP_INSTANT
                                                     : mds_pkg::MDS_STOP_DECEL;
         end
      end else begin
         nxt_cmd.dir_fwd = fn[`MDS_IF_DIR_SEL];
         if (!fn[`MDS_IF_HARD_STOP]) begin
            nxt_cmd.run       = 1'b0;
            nxt_cmd.stop_kind = mds_pkg::MDS_STOP_INSTANT;
         end else if (!fn[`MDS_IF_START]) begin
            nxt_cmd.run       = 1'b0;
            nxt_cmd.stop_kind = mds_pkg::MDS_STOP_DECEL;
         end else begin
            nxt_cmd.run       = 1'b1;
         end
      end
      // Alarm overrides: coast, except an external stop halts at once
      if (!ext_ok || ext_stop_ff) begin
         nxt_cmd.run       = 1'b0;
         nxt_cmd.stop_kind = mds_pkg::MDS_STOP_INSTANT;
      end else if (alarm_ff || core.alarm_event) begin
         nxt_cmd.run       = 1'b0;
         nxt_cmd.stop_kind = mds_pkg::MDS_STOP_COAST;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmd_ff <= '{run: 1'b0, dir_fwd: 1'b1, stop_kind: mds_pkg::MDS_STOP_DECEL,
                     speed_no: 3'h0, torque_lim_en: 1'b1, tool_unlocked: 1'b1, shaft_free: 1'b0};
      end else begin
         cmd_ff <= nxt_cmd;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rot_sense_ff <= 1'b0;
      end else if (core.rotating) begin
         rot_sense_ff <= core.rot_fwd;
      end
   end

   // Steps arriving during a pulse still count but cannot restart it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         step_cnt_ff  <= '0;
         tacho_ff     <= 1'b0;
         tacho_cnt_ff <= '0;
      end else begin
         if (core.shaft_step) begin
            if (step_cnt_ff == SW'(STEPS_PER_PULSE - 1)) begin
               step_cnt_ff <= '0;
            end else begin
               step_cnt_ff <= step_cnt_ff + SW'(1);
            end
         end
         if (tacho_ff) begin
            if (tacho_cnt_ff == TW'(TACHO_CYC - 1)) begin
               tacho_ff     <= 1'b0;
               tacho_cnt_ff <= '0;
            end else begin
               tacho_cnt_ff <= tacho_cnt_ff + TW'(1);
            end
         end else if (core.shaft_step && step_cnt_ff == SW'(STEPS_PER_PULSE - 1)) begin
            tacho_ff     <= 1'b1;
            tacho_cnt_ff <= '0;
         end
      end
   end

   always_comb begin
      if (core.speed_act >= core.speed_set) begin
         speed_diff = {1'b0, core.speed_act} - {1'b0, core.speed_set};
      end else begin
         speed_diff = {1'b0, core.speed_set} - {1'b0, core.speed_act};
      end
   end
   assign speed_ok   = core.rotating & (speed_diff <= {1'b0, cfg.va_width});

   function automatic logic out_sel(input logic [4:0] code, input logic [7:0] named,
                                    input logic [`MDS_N_NOTICE-1:0] notices);
      logic [4:0] idx;
      logic       r;
      idx = code - `MDS_OF_NOTICE_BASE;
      r   = 1'b0;
      if (code < `MDS_OF_NOTICE_BASE) begin
         r = named[code[2:0]];
      end else if (idx < 5'(`MDS_N_NOTICE)) begin
         r = notices[idx];
      end
      return r;
   endfunction

   logic [`MDS_N_DOUT-1:0][4:0] omap;
   logic [7:0]                  out_src;

   // Selection stays combinational so the output flops hold no temporaries
   always_comb begin
      omap    = cfg.map_custom ? cfg.out_map : `MDS_FACTORY_OUT_MAP;
      out_src = {speed_ok,
                 |notice_ff,
                 core.rotating,
                 alarm_ff,
                 rot_sense_ff,
                 core.torque_limited,
                 ~alarm_ff,
                 tacho_ff};
   end

   // Outputs lag the driving flops by one cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         direct_output_ff <= '0;
      end else begin
         for (int o = 0; o < `MDS_N_DOUT; o++) begin
            direct_output_ff[o] <= out_sel(omap[o], out_src, notice_ff);
         end
      end
   end

endmodule // mds_top

`default_nettype wire

//--- bench/mds_top_asserts.sv
/* Port checker for mds_top.
   Assumes a bind onto mds_top; most relations hold only under the factory map. */
`timescale 1ns/1ns
`default_nettype none
`include "mds_defines.svh"
module mds_top_asserts #(
   parameter int FILT_CYC        = 4,
   parameter int TACHO_CYC       = 5,
   parameter int STEPS_PER_PULSE = 1
) (
   input wire logic                     clk,
   input wire logic                     rst,
   input wire logic [`MDS_N_DIN-1:0]    direct_input,
   input wire mds_pkg::mds_cfg_t        cfg,
   input wire mds_pkg::mds_core_t       core,
   input wire logic [`MDS_N_DOUT-1:0]   direct_output_ff,
   input wire mds_pkg::mds_cmd_t        cmd_ff,
   input wire logic                     alarm_ff,
   input wire logic [`MDS_N_NOTICE-1:0] notice_ff
);
   logic [15:0]           hi_cnt_ff;
   logic [19:0]           stab_cnt_ff;
   logic [`MDS_N_DIN-1:0] din_ff;
   logic                  fac;
   assign fac = !cfg.map_custom;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) hi_cnt_ff <= '0;
      else if (direct_output_ff[0]) hi_cnt_ff <= hi_cnt_ff + 16'h0001;
      else hi_cnt_ff <= '0;
   end
   // Cycles since the raw terminals last moved, saturating
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         din_ff <= '0;
         stab_cnt_ff <= '0;
      end else begin
         din_ff <= direct_input;
         if (direct_input != din_ff) stab_cnt_ff <= '0;
         else if (stab_cnt_ff != 20'hfffff) stab_cnt_ff <= stab_cnt_ff + 20'h00001;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_alarm_shown;
      alarm_ff ##1 !direct_output_ff[1];
   endsequence
   sequence s_tacho_launch;
      !direct_output_ff[0] ##1 direct_output_ff[0];
   endsequence
   a_tacho_width: assert property (fac && !$past(cfg.map_custom) && $fell(direct_output_ff[0]) |->
      hi_cnt_ff == TACHO_CYC) else $error("tacho pulse width wrong");
   a_tacho_start: assert property (STEPS_PER_PULSE == 1 && fac && core.shaft_step &&
      !$past(core.shaft_step) && !direct_output_ff[0] |=> s_tacho_launch) else $error("tacho pulse missing");
   a_alarm_shown: assert property (fac && core.alarm_event |=> s_alarm_shown)
      else $error("alarm not shown on fault output");
   a_alarm_locked: assert property (alarm_ff && core.alarm_locked |=> alarm_ff)
      else $error("locked alarm was cleared");
   a_torque_out: assert property (fac && !$past(cfg.map_custom) && !$past(rst) |->
      direct_output_ff[2] == $past(core.torque_limited)) else $error("torque capped output wrong");
   a_rot_sense: assert property (fac && core.rotating |-> ##2 direct_output_ff[3] == $past(core.rot_fwd, 2))
      else $error("rotation sense wrong");
   a_notice_set: assert property (core.notice_cond != '0 |=>
      (notice_ff & $past(core.notice_cond)) == $past(core.notice_cond)) else $error("notice bit not set");
   a_notice_sum: assert property (cfg.map_custom && cfg.out_map[2] == `MDS_OF_NOTICE_SUM |=>
      direct_output_ff[2] == |$past(notice_ff)) else $error("notice summary wrong");
   a_speed_filter: assert property (fac && $changed(cmd_ff.speed_no) |-> stab_cnt_ff >= FILT_CYC)
      else $error("speed number followed an unfiltered input");
endmodule // mds_top_asserts
bind mds_top mds_top_asserts #(
   .FILT_CYC(FILT_CYC), .TACHO_CYC(TACHO_CYC), .STEPS_PER_PULSE(STEPS_PER_PULSE)
) u_asserts (.clk(clk), .rst(rst), .direct_input(direct_input), .cfg(cfg), .core(core),
   .direct_output_ff(direct_output_ff), .cmd_ff(cmd_ff), .alarm_ff(alarm_ff), .notice_ff(notice_ff));
`default_nettype wire

//--- bench/mds_ctrl_model.sv
/* Model of the external controller that drives the six terminals.
   Assumes the bench calls its tasks; levels change just after clk rises. */
`timescale 1ns/1ns
`default_nettype none
module mds_ctrl_model #(
   parameter int HOLD_CYC = 12
) (
   input  wire logic       clk,
   output var  logic [5:0] terminals
);
   initial terminals = 6'h00;
   task automatic apply(input logic [5:0] lvl);
      @(posedge clk);
      terminals <= lvl;
      repeat (HOLD_CYC) @(posedge clk);
      #1;
   endtask
   // Too short on purpose, used only where the bench wants a refusal
   task automatic glitch(input int idx, input int len);
      @(posedge clk);
      terminals[idx] <= ~terminals[idx];
      repeat (len) @(posedge clk);
      terminals[idx] <= ~terminals[idx];
      repeat (HOLD_CYC) @(posedge clk);
      #1;
   endtask
endmodule // mds_ctrl_model
`default_nettype wire

//--- bench/mds_top_bench.sv
/* Self-checking bench for mds_top with short filter and tacho counts.
   Assumes mds_ctrl_model on the terminals; core status is driven here. */
`timescale 1ns/1ns
`default_nettype none
`include "mds_defines.svh"
module mds_top_bench;
   localparam int FILT = 4;
   localparam int TACH = 5;
   logic                     clk;
   logic                     rst;
   logic [`MDS_N_DIN-1:0]    din;
   mds_pkg::mds_cfg_t        cfg;
   mds_pkg::mds_core_t       core;
   logic [`MDS_N_DOUT-1:0]   dout;
   mds_pkg::mds_cmd_t        cmd;
   logic                     alarm;
   logic [`MDS_N_NOTICE-1:0] notice;
   int                       err_count;
   int                       n_checks;
   mds_top #(.FILT_CYC(FILT), .TACHO_CYC(TACH), .STEPS_PER_PULSE(1)) dut (.clk(clk), .rst(rst),
      .direct_input(din), .cfg(cfg), .core(core), .direct_output_ff(dout), .cmd_ff(cmd),
      .alarm_ff(alarm), .notice_ff(notice));
   // Hold longer than sync plus filter plus clear latency
   mds_ctrl_model #(.HOLD_CYC(FILT + 8)) ctl (.clk(clk), .terminals(din));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic set_rot(input logic r, input logic f);
      @(posedge clk);
      core.rotating <= r;
      core.rot_fwd <= f;
      cyc(3);
   endtask
   task automatic fire_alarm();
      @(posedge clk) core.alarm_event <= 1'b1;
      @(posedge clk) core.alarm_event <= 1'b0;
      cyc(2);
   endtask
   task automatic s_three_wire();
      ctl.apply(6'h06);
      chk(cmd.run, 1'b0);
      ctl.apply(6'h07);
      chk({cmd.run, cmd.dir_fwd}, 2'b11);
      ctl.apply(6'h03);
      chk({cmd.run, cmd.dir_fwd}, 2'b10);
      ctl.apply(6'h02);
      chk({cmd.run, cmd.stop_kind}, {1'b0, mds_pkg::MDS_STOP_DECEL});
      ctl.apply(6'h03);
      ctl.apply(6'h01);
      chk({cmd.run, cmd.stop_kind}, {1'b0, mds_pkg::MDS_STOP_INSTANT});
      ctl.apply(6'h00);
   endtask
   task automatic s_speed();
      for (int i = 0; i < 4; i++) begin
         ctl.apply({1'b0, i[1:0], 3'b000});
         chk(cmd.speed_no, i[2:0]);
      end
      ctl.glitch(3, 2);
      chk(cmd.speed_no, 3'h3);
      ctl.apply(6'h00);
   endtask
   task automatic s_two_wire();
      @(posedge clk) cfg.two_wire <= 1'b1;
      ctl.apply(6'h01);
      chk({cmd.run, cmd.dir_fwd}, 2'b11);
      ctl.apply(6'h00);
      chk({cmd.run, cmd.stop_kind}, {1'b0, mds_pkg::MDS_STOP_DECEL});
      ctl.apply(6'h02);
      chk({cmd.run, cmd.dir_fwd}, 2'b10);
      ctl.apply(6'h06);
      ctl.apply(6'h04);
      chk({cmd.run, cmd.stop_kind}, {1'b0, mds_pkg::MDS_STOP_INSTANT});
      ctl.apply(6'h03);
      chk(cmd.run, 1'b0);
      ctl.apply(6'h00);
      @(posedge clk) cfg.two_wire <= 1'b0;
      ctl.apply(6'h01);
      chk(cmd.run, 1'b0);
      ctl.apply(6'h00);
   endtask
   task automatic s_status();
      int hi;
      @(posedge clk) core.torque_limited <= 1'b1;
      cyc(3);
      chk(dout[2], 1'b1);
      @(posedge clk) core.torque_limited <= 1'b0;
      cyc(3);
      chk(dout[2], 1'b0);
      set_rot(1'b1, 1'b1);
      chk(dout[3], 1'b1);
      set_rot(1'b0, 1'b0);
      chk(dout[3], 1'b1);
      set_rot(1'b1, 1'b0);
      chk(dout[3], 1'b0);
      set_rot(1'b0, 1'b0);
      for (int k = 0; k < 3; k++) begin
         hi = 0;
         @(posedge clk) core.shaft_step <= 1'b1;
         @(posedge clk) core.shaft_step <= 1'b0;
         repeat (12) begin
            cyc(1);
            if (dout[0] === 1'b1) hi++;
         end
         chk(hi[17:0], TACH);
      end
   endtask
   task automatic s_alarm();
      fire_alarm();
      chk({alarm, dout[1], cmd.stop_kind}, {2'b10, mds_pkg::MDS_STOP_COAST});
      ctl.apply(6'h03);
      ctl.apply(6'h23);
      chk(alarm, 1'b1);
      ctl.apply(6'h00);
      ctl.apply(6'h20);
      chk({alarm, dout[1]}, 2'b01);
      ctl.apply(6'h00);
      @(posedge clk) core.alarm_locked <= 1'b1;
      fire_alarm();
      ctl.apply(6'h20);
      chk(alarm, 1'b1);
      @(posedge clk) core.alarm_locked <= 1'b0;
      ctl.apply(6'h00);
      @(posedge clk) rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      cyc(2);
   endtask
   task automatic s_map_a();
      @(posedge clk);
      cfg.map_custom <= 1'b1;
      cfg.notice_auto_clr <= 1'b0;
      cfg.in_map <= {`MDS_IF_NOTICE_CLR, `MDS_IF_TQ_EN, `MDS_IF_TQ_EN, `MDS_IF_SPD2, `MDS_IF_SPD1, `MDS_IF_SPD0};
      cfg.out_map <= {`MDS_OF_NOTICE_BASE + 5'h03, `MDS_OF_NOTICE_SUM, `MDS_OF_FAULT_NO, `MDS_OF_MOVING};
      ctl.apply(6'h08);
      chk(cmd.torque_lim_en, 1'b0);
      for (int i = 0; i < 8; i++) begin
         ctl.apply({3'b011, i[2:0]});
         chk(cmd.speed_no, i[2:0]);
      end
      chk({cmd.torque_lim_en, cmd.tool_unlocked}, 2'b11);
      set_rot(1'b1, 1'b1);
      chk(dout[0], 1'b1);
      set_rot(1'b0, 1'b0);
      chk(dout[0], 1'b0);
      @(posedge clk) core.notice_cond <= 18'h3ffff;
      cyc(3);
      chk({notice[3], dout[3], dout[2]}, 3'b111);
      @(posedge clk) core.notice_cond <= 18'h00000;
      cyc(3);
      chk(notice, 18'h3ffff);
      ctl.apply(6'h38);
      chk({notice[3], dout[2]}, 2'b00);
      ctl.apply(6'h03);
   endtask
   task automatic s_map_b();
      @(posedge clk);
      cfg.in_map <= {`MDS_IF_NONE, `MDS_IF_NONE, `MDS_IF_NONE, `MDS_IF_SHAFT_REL, `MDS_IF_TOOL_UNLOCK, `MDS_IF_EXT_FAULT};
      cfg.out_map <= {5'h1f, 5'h1f, `MDS_OF_FAULT_NO, `MDS_OF_SPD_REACHED};
      cfg.load_hold_en <= 1'b1;
      cfg.va_width <= 16'h7fff;
      core.speed_set <= 16'h7fff;
      core.shaft_held <= 1'b1;
      ctl.apply(6'h03);
      chk({cmd.tool_unlocked, cmd.torque_lim_en, alarm}, 3'b110);
      ctl.apply(6'h01);
      chk(cmd.tool_unlocked, 1'b0);
      ctl.apply(6'h05);
      chk(cmd.shaft_free, 1'b1);
      @(posedge clk) core.speed_act <= 16'hfffe;
      set_rot(1'b1, 1'b1);
      chk(dout[0], 1'b1);
      @(posedge clk) core.speed_act <= 16'hffff;
      cyc(3);
      chk(dout[0], 1'b0);
      set_rot(1'b0, 1'b0);
      ctl.apply(6'h04);
      chk({alarm, cmd.run, cmd.stop_kind, dout[1]}, {2'b10, mds_pkg::MDS_STOP_INSTANT, 1'b1});
   endtask
   task automatic complete_run();
      if (err_count == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      err_count = 0;
      n_checks = 0;
      cfg = '0;
      cfg.notice_auto_clr = 1'b1;
      cfg.in_map = `MDS_FACTORY_IN_MAP;
      cfg.out_map = `MDS_FACTORY_OUT_MAP;
      core = '0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      cyc(2);
      chk({cmd.run, cmd.torque_lim_en, cmd.tool_unlocked, alarm}, 4'h6);
      chk(dout, 4'h2);
      s_three_wire();
      s_speed();
      s_two_wire();
      s_status();
      s_alarm();
      s_map_a();
      s_map_b();
      complete_run();
   end
endmodule // mds_top_bench
`default_nettype wire
